/* verilog/load_adaptive_current_scaler.sv */
// Decided for this implementation: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - config word with bits 19:17 equal 101 writes the adaptive config register.
// - bit 15 picks the floor: 0 half, 1 quarter of programmed scale.
// - bits 14:13 pick high samples per decrement: 32, 8, 2, 1.
// - upper threshold is (lower + offset + 1) times 32; reaching it counts down.
// - each low sample raises the factor by 1, 2, 4 or 8 steps.
// - lower threshold zero disables regulation; load samples have no effect.
// - sample below lower threshold times 32 raises the factor.
// - programmed 5-bit scale means (value + 1) / 32, the upper bound.

module load_adaptive_current_scaler
  import load_adaptive_current_pkg::*;
#(
  parameter int SAMPLE_W = 10
)
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                ce,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         paddr,
  input  wire logic [31:0]         pwdata,
  input  wire logic                sample_valid,
  input  wire logic [SAMPLE_W-1:0] load_measurement_value,
  output logic                     pready,
  output logic                     pslverr,
  output logic      [31:0]         prdata,
  output logic      [SCALE_W-1:0]  current_scale_factor,
  output logic                     regulation_active
);

  // ==========================================================
  // state
  logic [CFG_W-1:0]   cfg_q,     cfg_d;
  logic [SCALE_W-1:0] cs_q,      cs_d;
  logic [SCALE_W-1:0] factor_q,  factor_d;
  logic [5:0]         count_q,   count_d;
  logic               active_q,  active_d;
  logic               pready_q,  pready_d;
  logic               pslverr_q, pslverr_d;
  logic [31:0]        prdata_q,  prdata_d;

  // ==========================================================
  // configuration fields
  logic               min_sel;
  logic [1:0]         dec_sel;
  logic [3:0]         upper_ofs;
  logic [1:0]         inc_sel;
  logic [3:0]         lower_thr;
  logic [SAMPLE_W:0]  lower_lim;
  logic [SAMPLE_W:0]  upper_lim;
  logic [5:0]         dec_target;
  logic [3:0]         inc_amt;
  logic               is_low;
  logic               is_high;
  logic               do_dec;
  logic [SCALE_W-1:0] stepped;
  logic               setup;
  logic               access;
  logic               mapped;

  assign min_sel   = cfg_q[MIN_SEL_BIT];
  assign dec_sel   = cfg_q[DEC_HI:DEC_LO];
  assign upper_ofs = cfg_q[OFS_HI:OFS_LO];
  assign inc_sel   = cfg_q[INC_HI:INC_LO];
  assign lower_thr = cfg_q[LOW_HI:LOW_LO];

  // ==========================================================
  // thresholds and decodes
  always_comb
  begin
    lower_lim = (SAMPLE_W+1)'({lower_thr, 5'h00});
    upper_lim = (SAMPLE_W+1)'({5'h00, lower_thr} + {5'h00, upper_ofs} + 9'h001)
                << THRESH_SHIFT;
    unique case (dec_sel)
      2'h0: dec_target = DEC_COUNT_0;
      2'h1: dec_target = DEC_COUNT_1;
      2'h2: dec_target = DEC_COUNT_2;
      2'h3: dec_target = DEC_COUNT_3;
    endcase
    unique case (inc_sel)
      2'h0: inc_amt = 4'h1;
      2'h1: inc_amt = 4'h2;
      2'h2: inc_amt = 4'h4;
      2'h3: inc_amt = 4'h8;
    endcase
    is_low  = sample_valid && ({1'b0, load_measurement_value} < lower_lim);
    is_high = sample_valid && ({1'b0, load_measurement_value} >= upper_lim);
    do_dec  = is_high && ((count_q + 6'h01) >= dec_target);
  end

  // ==========================================================
  // step and clamp unit
  scale_step_unit u_step
  (
    .cur     (factor_q),
    .cs      (cs_q),
    .min_sel (min_sel),
    .inc_en  (is_low),
    .inc_amt (inc_amt),
    .dec_en  (do_dec),
    .next    (stepped)
  );

  // ==========================================================
  // regulator next state
  always_comb
  begin
    factor_d = factor_q;
    count_d  = count_q;
    active_d = (lower_thr != 4'h0);
    if (lower_thr == 4'h0)
    begin
      // disabled: full programmed scale, no history kept
      factor_d = cs_q;
      count_d  = 6'h00;
    end
    else
    begin
      // clamp also runs on idle cycles so a new scale takes hold at once
      factor_d = stepped;
      if (is_low || do_dec)
      begin
        count_d = 6'h00;
      end
      else if (is_high)
      begin
        count_d = count_q + 6'h01;
      end
    end
  end

  // ==========================================================
  // apb slave next state, zero-wait: answer staged in setup cycle
  always_comb
  begin
    setup     = psel && !penable;
    access    = psel && penable && pready_q;
    mapped    = (paddr == CFG_ADDR) || (paddr == CURRENT_ADDR) ||
                (paddr == STATUS_ADDR) || (paddr == COUNT_ADDR);
    cfg_d     = cfg_q;
    cs_d      = cs_q;
    pready_d  = setup;
    pslverr_d = setup && !mapped;
    prdata_d  = 32'h0000_0000;
    if (setup && !pwrite)
    begin
      unique case (1'b1)
        (paddr == CURRENT_ADDR): prdata_d = {27'h000_0000, cs_q};
        (paddr == STATUS_ADDR):  prdata_d = {26'h000_0000, active_q, factor_q};
        (paddr == COUNT_ADDR):   prdata_d = {26'h000_0000, count_q};
        default:                 prdata_d = 32'h0000_0000; // config is write-only
      endcase
    end
    if (access && pwrite)
    begin
      // words with another select field belong to other registers: ignored
      if ((paddr == CFG_ADDR) && (pwdata[SEL_HI:SEL_LO] == CFG_SELECT))
      begin
        cfg_d = pwdata[CFG_W-1:0];
      end
      if (paddr == CURRENT_ADDR)
      begin
        cs_d = pwdata[SCALE_W-1:0];
      end
    end
  end

  // ==========================================================
  // regulator registers; ce low freezes them so a paused drive keeps its scale
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      factor_q  <= CS_RESET;
      count_q   <= 6'h00;
      active_q  <= 1'b0;
    end
    else if (ce)
    begin
      factor_q  <= factor_d;
      count_q   <= count_d;
      active_q  <= active_d;
    end
  end

  // ==========================================================
  // bus registers; the answer freezes with ce too, so a setup cycle that ends with ce low never gets pready
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cfg_q     <= CFG_RESET;
      cs_q      <= CS_RESET;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else if (ce)
    begin
      cfg_q     <= cfg_d;
      cs_q      <= cs_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q  <= prdata_d;
    end
  end

  assign pready               = pready_q;
  assign pslverr              = pslverr_q;
  assign prdata               = prdata_q;
  assign current_scale_factor = factor_q;
  assign regulation_active    = active_q;

endmodule : load_adaptive_current_scaler

/* verilog/load_adaptive_current_pkg.sv */
package load_adaptive_current_pkg;

  // ==========================================================
  // register map, byte addresses on the bus
  localparam logic [31:0] CFG_ADDR        = 32'h0000_0000;
  localparam logic [31:0] CURRENT_ADDR    = 32'h0000_0004;
  localparam logic [31:0] STATUS_ADDR     = 32'h0000_0008;
  localparam logic [31:0] COUNT_ADDR      = 32'h0000_000C;

  // ==========================================================
  // configuration word layout
  localparam int          CFG_W           = 20;
  localparam int          SEL_HI          = 19;
  localparam int          SEL_LO          = 17;
  localparam logic [2:0]  CFG_SELECT      = 3'h5;
  localparam int          MIN_SEL_BIT     = 15;
  localparam int          DEC_HI          = 14;
  localparam int          DEC_LO          = 13;
  localparam int          OFS_HI          = 11;
  localparam int          OFS_LO          = 8;
  localparam int          INC_HI          = 6;
  localparam int          INC_LO          = 5;
  localparam int          LOW_HI          = 3;
  localparam int          LOW_LO          = 0;
  localparam logic [19:0] CFG_RESET       = 20'h0_0000;

  // ==========================================================
  // current scale and scaling factor
  localparam int          SCALE_W         = 5;
  localparam logic [4:0]  CS_RESET        = 5'h1F;
  localparam int          THRESH_SHIFT    = 5;

  // ==========================================================
  // decrement sample counts per select code
  localparam logic [5:0]  DEC_COUNT_0     = 6'h20;
  localparam logic [5:0]  DEC_COUNT_1     = 6'h08;
  localparam logic [5:0]  DEC_COUNT_2     = 6'h02;
  localparam logic [5:0]  DEC_COUNT_3     = 6'h01;

endpackage : load_adaptive_current_pkg

/* verilog/scale_step_unit.sv */
`timescale 1ns/1ps

module scale_step_unit
  import load_adaptive_current_pkg::*;
(
  input  wire logic [SCALE_W-1:0] cur,
  input  wire logic [SCALE_W-1:0] cs,
  input  wire logic               min_sel,
  input  wire logic               inc_en,
  input  wire logic [3:0]         inc_amt,
  input  wire logic               dec_en,
  output logic      [SCALE_W-1:0] next
);

  logic [SCALE_W:0]   cs_plus;
  logic [SCALE_W:0]   floor_plus;
  logic [SCALE_W-1:0] floor_code;
  logic [SCALE_W+1:0] sum;

  // ==========================================================
  // floor: half or quarter of the programmed scale, as a code
  always_comb
  begin
    cs_plus    = {1'b0, cs} + 6'h01;
    floor_plus = min_sel ? (cs_plus >> 2) : (cs_plus >> 1);
    // a quarter of a tiny scale rounds to zero; hold at least one step
    floor_code = (floor_plus == 6'h00) ? 5'h00 : floor_plus[SCALE_W-1:0] - 5'h01;
  end

  // ==========================================================
  // step, then clamp into the floor..scale window
  always_comb
  begin
    sum = {2'b00, cur};
    if (inc_en)
    begin
      sum = sum + {3'b000, inc_amt};
    end
    else if (dec_en && (cur != 5'h00))
    begin
      sum = sum - 7'h01;
    end
    if (sum > {2'b00, cs})
    begin
      next = cs;
    end
    else if (sum < {2'b00, floor_code})
    begin
      next = floor_code;
    end
    else
    begin
      next = sum[SCALE_W-1:0];
    end
  end

endmodule : scale_step_unit

/* tb/load_adaptive_current_checker.sv */
`timescale 1ns/1ps
// ==========
// port checks
module load_adaptive_current_checker
  import load_adaptive_current_pkg::*;
#(
  parameter int SAMPLE_W = 10
)
(
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                ce,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [31:0]         paddr,
  input wire logic [31:0]         pwdata,
  input wire logic                sample_valid,
  input wire logic [SAMPLE_W-1:0] load_measurement_value,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [31:0]         prdata,
  input wire logic [SCALE_W-1:0]  current_scale_factor,
  input wire logic                regulation_active
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // bus answers exactly one cycle after setup
  AST_READY_AFTER_SETUP: assert property (psel && !penable && ce |=> pready) else $error("no ready");
  AST_READY_ONE_CYCLE: assert property (pready |=> !pready) else $error("ready too long");
  AST_ERR_UNMAPPED: assert property (psel && !penable && ce && paddr > 32'hC |=> pslverr && pready)
    else $error("no slave error");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready) else $error("lone slave error");
  AST_RDATA_IDLE: assert property (!pready |-> prdata == 32'h0) else $error("idle read data");
  // zero load is always below a nonzero lower threshold, so never a decrease
  AST_ZERO_LOAD_RAISES: assert property (regulation_active && sample_valid && ce &&
    load_measurement_value == '0 && !psel && !$past(psel) |=> current_scale_factor >=
    $past(current_scale_factor)) else $error("factor fell on low load");
  // without samples or bus writes the factor must hold
  AST_HOLD_NO_SAMPLE: assert property ((!psel && !sample_valid && ce)[*2] |=>
    $stable(current_scale_factor)) else $error("factor moved");
  AST_RESET_VALUES: assert property ($rose(presetn) |-> current_scale_factor == 5'h1F &&
    !regulation_active) else $error("bad reset values");
  // clock enable low must freeze the regulator outputs
  AST_CE_FREEZES: assert property (!ce |=> $stable(current_scale_factor) &&
    $stable(regulation_active)) else $error("state moved with clock enable low");
  COV_WRITE: cover property (psel && penable && pwrite && pready);
  COV_ERR: cover property (pslverr);
  COV_FLOOR: cover property (regulation_active && current_scale_factor == 5'h07);
endmodule : load_adaptive_current_checker

bind load_adaptive_current_scaler load_adaptive_current_checker #(.SAMPLE_W(SAMPLE_W))
  i_load_adaptive_current_checker (.*);

/* tb/host_model.sv */
`timescale 1ns/1ps
// ==========
// host side: bus transfers and load samples
module host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             ce = 1'h1,
  output logic             psel = 1'h0,
  output logic             penable = 1'h0,
  output logic             pwrite = 1'h0,
  output logic [31:0]      paddr = 32'h0,
  output logic [31:0]      pwdata = 32'h0,
  output logic             sample_valid = 1'h0,
  output logic [9:0]       load_measurement_value = 10'h0
);
  // request held until ready is sampled; bounded so a dead slave cannot hang
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output logic ok);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'h1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    ok = n < 20;
    q = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
  endtask : xfer
  // n back-to-back samples of one value
  task automatic feed(input logic [9:0] v, input int n);
    if (n == 0) return;
    @(posedge pclk);
    sample_valid           <= 1'h1;
    load_measurement_value <= v;
    repeat (n) @(posedge pclk);
    sample_valid <= 1'h0;
    load_measurement_value <= ~v;
  endtask : feed
  // clock enable low while low-load samples are offered: nothing may move
  task automatic freeze(input int n);
    @(posedge pclk);
    ce                     <= 1'h0;
    sample_valid           <= 1'h1;
    load_measurement_value <= 10'h000;
    repeat (n) @(posedge pclk);
    ce           <= 1'h1;
    sample_valid <= 1'h0;
  endtask : freeze
endmodule : host_model

/* tb/load_adaptive_current_scaler_test.sv */
`timescale 1ns/1ps
// ==========
// bench top
module load_adaptive_current_scaler_test
  import load_adaptive_current_pkg::*;
;
  logic pclk = 1'h0, presetn = 1'h0, ce, psel, penable, pwrite, sample_valid;
  logic pready, pslverr, regulation_active;
  logic [31:0] paddr, pwdata, prdata;
  logic [9:0]  load_measurement_value;
  logic [4:0]  current_scale_factor;
  int failures = 0, check_count = 0;
  always #5 pclk = ~pclk;
  load_adaptive_current_scaler i_load_adaptive_current_scaler (.*);
  host_model i_host_model (.*);
  task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("[ERR] %s expected %h seen %h", w, e, g);
    end
  endtask : chk
  // one bus access, judged on completion, error flag and read data
  task automatic bus(input logic w, input logic [31:0] a, d, e, input logic eerr);
    logic [31:0] q;
    logic        err, ok;
    i_host_model.xfer(w, a, d, q, err, ok);
    if (!ok)
    begin
      failures++;
      $display("[ERR] pready expected 1 seen timeout");
      wrap_up();
    end
    chk("slverr", {31'h0, eerr}, {31'h0, err});
    if (!w) chk("rdata", e, q);
  endtask : bus
  // lower threshold lo, offset 1; select code 101 in the top bits
  task automatic cfg(input logic m, input logic [1:0] dc, ic, input logic [3:0] lo);
    bus(1'h1, CFG_ADDR, {12'h0, CFG_SELECT, 1'h0, m, dc, 1'h0, 4'h1, 1'h0, ic, 1'h0, lo},
        0, 1'h0);
    repeat (2) @(posedge pclk);
  endtask : cfg
  task automatic feedchk(input logic [9:0] v, input int n, input logic [4:0] e);
    i_host_model.feed(v, n);
    @(negedge pclk);
    chk("factor", {27'h0, e}, {27'h0, current_scale_factor});
  endtask : feedchk
  task automatic reset_and_map();
    bus(1'h0, CURRENT_ADDR, 0, 32'h1F, 1'h0);
    bus(1'h0, STATUS_ADDR, 0, 32'h1F, 1'h0);
    bus(1'h0, CFG_ADDR, 0, 32'h0, 1'h0);
    bus(1'h0, 32'h10, 0, 32'h0, 1'h1);
  endtask : reset_and_map
  task automatic disabled_and_bad_select();
    feedchk(10'h0, 4, 5'h1F);
    bus(1'h1, CFG_ADDR, 32'h0008_6102, 0, 1'h0);
    repeat (2) @(posedge pclk);
    chk("active", 0, {31'h0, regulation_active});
  endtask : disabled_and_bad_select
  // upper threshold (2+1+1)*32 = 128, lower 64; half floor of 31 is 15
  task automatic thresholds_half_floor();
    cfg(1'h0, 2'h3, 2'h0, 4'h2);
    chk("active", 1, {31'h0, regulation_active});
    bus(1'h0, STATUS_ADDR, 0, 32'h3F, 1'h0);
    feedchk(10'h07F, 1, 5'h1F);
    feedchk(10'h080, 1, 5'h1E);
    feedchk(10'h080, 20, 5'h0F);
    feedchk(10'h040, 1, 5'h0F);
    i_host_model.freeze(4);
    @(negedge pclk);
    chk("frozen", 32'h0F, {27'h0, current_scale_factor});
    feedchk(10'h03F, 1, 5'h10);
  endtask : thresholds_half_floor
  task automatic quarter_floor_and_steps();
    logic [4:0] s[4] = '{5'h1, 5'h2, 5'h4, 5'h8};
    logic [4:0] f = 5'h07;
    cfg(1'h1, 2'h3, 2'h0, 4'h2);
    feedchk(10'h3FF, 30, f);
    for (int c = 0; c < 4; c++)
    begin
      cfg(1'h1, 2'h3, c[1:0], 4'h2);
      f += s[c];
      feedchk(10'h0, 1, f);
    end
    feedchk(10'h0, 2, 5'h1F);
  endtask : quarter_floor_and_steps
  task automatic decrement_counts();
    int n[4] = '{32, 8, 2, 1};
    for (int c = 0; c < 4; c++)
    begin
      cfg(1'h0, c[1:0], 2'h0, 4'h2);
      feedchk(10'h0C8, n[c] - 1, 5'h1F - c[4:0]);
      bus(1'h0, COUNT_ADDR, 0, n[c] - 1, 1'h0);
      feedchk(10'h0C8, 1, 5'h1E - c[4:0]);
    end
  endtask : decrement_counts
  task automatic scale_clamp_and_off();
    bus(1'h1, CURRENT_ADDR, 32'h0F, 0, 1'h0);
    feedchk(10'h0, 1, 5'h0F);
    cfg(1'h0, 2'h0, 2'h0, 4'h0);
    bus(1'h0, STATUS_ADDR, 0, 32'h0F, 1'h0);
  endtask : scale_clamp_and_off
  task automatic wrap_up();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    reset_and_map();
    disabled_and_bad_select();
    thresholds_half_floor();
    quarter_floor_and_steps();
    decrement_counts();
    scale_clamp_and_off();
    wrap_up();
  end
endmodule : load_adaptive_current_scaler_test
